// ==== pkg/param_update_regs.svh ====
// command locations, key halves, control codes and reset values
`ifndef PARAM_UPDATE_REGS_SVH
`define PARAM_UPDATE_REGS_SVH
// Operation
// - Writing zero to the block access enable location turns on block parameter access.
// - A byte written to the class select location picks the subclass shown in the window.
// - A byte written to the block index location picks a 32-byte block, index zero for offsets 0-31.
// - A parameter is read at window address 0x40 plus its offset modulo 32.
// - Reading the checksum location returns the checksum of the selected block.
// - A window write replaces the staged byte at that offset of the selected block.
// - Staged bytes are committed only when a correct checksum for the whole window is written.
// - The checksum is 255 minus the 8-bit sum of all window bytes.
// - The reset control command makes committed values take effect; here it reloads only operation config B, and only while unlocked.
// - A device that was locked before unlocking locks itself again after the reset command.
// - The lock control command puts the device in the locked state.
// - With bit 7 of operation config B set, gauging uses the host-written temperature only.
// - Updates are taken while the gauge keeps running, with no boot mode or full image load.
`define CTRL_LO_ADDR 8'h00
`define CTRL_HI_ADDR 8'h01
`define HOST_TEMP_LO_ADDR 8'h06
`define HOST_TEMP_HI_ADDR 8'h07
`define CLASS_ADDR 8'h3e
`define BLOCK_ADDR 8'h3f
`define WIN_BASE_ADDR 8'h40
`define WIN_LAST_ADDR 8'h5f
`define SUM_ADDR 8'h60
`define ACCESS_EN_ADDR 8'h61
`define ACCESS_EN_VAL 8'h00
`define KEY_LO 16'h0414
`define KEY_HI 16'h3672
`define CMD_RESET 16'h0041
`define CMD_LOCK 16'h0020
`define SUM_BASE 8'hff
`define OPCFG_B_CLASS 8'h40
`define OPCFG_B_BLOCK 8'h00
`define OPCFG_B_OFS 5'h04
`define OPCFG_B_RST 8'h4a
`define OPCFG_B_HOST_TEMP_BIT 7
`define BLOCK_BYTES 32
`define NV_BLOCKS 16
`endif

// ==== pkg/param_update_pkg.sv ====
// types shared by the parameter update block
package param_update_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmd_req_t;

  typedef enum logic [1:0] {
    LOCKED = 2'b01,
    OPEN = 2'b10
  } lock_state_t;
endpackage

// ==== hw/param_block_update.sv ====
// command-driven nonvolatile parameter block access with lock and checksum commit
`timescale 1ns/1ps
`include "param_update_regs.svh"
module param_block_update (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire param_update_pkg::cmd_req_t cmd,
  output logic [7:0] cmd_rdata,
  output logic locked,
  output logic block_access_on,
  output logic nv_commit,
  output logic [7:0] operation_config_b,
  output logic host_temp_write_enable,
  input wire logic [15:0] ext_temp,
  input wire logic [15:0] int_temp,
  input wire logic int_temp_sel,
  output logic [15:0] gauge_temp
);
  param_update_pkg::lock_state_t lock_r;
  logic was_locked_r;
  logic key_half_r;
  logic blk_en_r;
  logic [7:0] class_r;
  logic [7:0] block_r;
  logic [7:0] nv_r [`NV_BLOCKS][`BLOCK_BYTES];
  logic [7:0] win_r [`BLOCK_BYTES];
  logic [7:0] opcfg_r;
  logic [15:0] host_temp_r;
  logic [7:0] ctrl_lo_r;
  logic [7:0] rdata_r;
  logic commit_r;
  logic [15:0] temp_r;

  logic [3:0] cur_idx;
  logic [3:0] sel_idx;
  logic [3:0] opcfg_idx;
  logic [7:0] win_sum;
  logic [7:0] win_chk;
  logic [15:0] ctrl_word;
  logic ctrl_go;
  logic is_win;
  logic [4:0] win_ofs;
  logic sum_ok;

  // address strobes, at most one high per command
  logic hit_ctrl_lo;
  logic hit_ctrl_hi;
  logic hit_temp_lo;
  logic hit_temp_hi;
  logic hit_class;
  logic hit_block;
  logic hit_win;
  logic hit_sum;
  logic hit_access;
  logic open_wr;
  logic blk_wr;
  logic commit_go;
  logic [7:0] rdata_nxt;

  // blocks are folded by low class bits and block index, so storage stays small
  assign cur_idx = {class_r[2:0], block_r[0]};
  assign opcfg_idx = {3'(`OPCFG_B_CLASS), 1'(`OPCFG_B_BLOCK)};
  assign is_win = (cmd.addr >= `WIN_BASE_ADDR) && (cmd.addr <= `WIN_LAST_ADDR);
  assign win_ofs = cmd.addr[4:0];
  assign ctrl_word = {cmd.wdata, ctrl_lo_r};
  assign ctrl_go = cmd.wr && hit_ctrl_hi;

  always_comb begin
    win_sum = 8'h00;
    for (int i = 0; i < `BLOCK_BYTES; i++) begin
      win_sum = win_sum + win_r[i];
    end
    win_chk = `SUM_BASE - win_sum;
  end

  assign sum_ok = (cmd.wdata == win_chk);

  // one strobe per command location; the window range takes one slot
  // a single decode keeps read and write paths agreeing on the map
  always_comb begin
    hit_ctrl_lo = 1'b0;
    hit_ctrl_hi = 1'b0;
    hit_temp_lo = 1'b0;
    hit_temp_hi = 1'b0;
    hit_class = 1'b0;
    hit_block = 1'b0;
    hit_win = 1'b0;
    hit_sum = 1'b0;
    hit_access = 1'b0;
    if (cmd.addr == `CTRL_LO_ADDR) begin
      hit_ctrl_lo = 1'b1;
    end else if (cmd.addr == `CTRL_HI_ADDR) begin
      hit_ctrl_hi = 1'b1;
    end else if (cmd.addr == `HOST_TEMP_LO_ADDR) begin
      hit_temp_lo = 1'b1;
    end else if (cmd.addr == `HOST_TEMP_HI_ADDR) begin
      hit_temp_hi = 1'b1;
    end else if (cmd.addr == `CLASS_ADDR) begin
      hit_class = 1'b1;
    end else if (cmd.addr == `BLOCK_ADDR) begin
      hit_block = 1'b1;
    end else if (is_win) begin
      hit_win = 1'b1;
    end else if (cmd.addr == `SUM_ADDR) begin
      hit_sum = 1'b1;
    end else if (cmd.addr == `ACCESS_EN_ADDR) begin
      hit_access = 1'b1;
    end
  end

  // writes past the lock, and past block access as well
  assign open_wr = cmd.wr && (lock_r == param_update_pkg::OPEN);
  assign blk_wr = open_wr && blk_en_r;
  assign commit_go = blk_wr && hit_sum && sum_ok;

  // class or block selection picks the storage slot to stage from
  always_comb begin
    sel_idx = cur_idx;
    if (blk_wr) begin
      if (hit_class) begin
        sel_idx = {cmd.wdata[2:0], block_r[0]};
      end else if (hit_block) begin
        sel_idx = {class_r[2:0], cmd.wdata[0]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_lo_r <= 8'h00;
    end else if (cmd.wr && hit_ctrl_lo) begin
      ctrl_lo_r <= cmd.wdata;
    end
  end

  // lock handling
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lock_r <= param_update_pkg::LOCKED;
      was_locked_r <= 1'b0;
      key_half_r <= 1'b0;
    end else if (ctrl_go) begin
      key_half_r <= 1'b0;
      case (lock_r)
        param_update_pkg::LOCKED: begin
          if (ctrl_word == `KEY_LO) begin
            key_half_r <= 1'b1;
          end else if (ctrl_word == `KEY_HI && key_half_r) begin
            lock_r <= param_update_pkg::OPEN;
            was_locked_r <= 1'b1;
          end
        end
        param_update_pkg::OPEN: begin
          if (ctrl_word == `CMD_LOCK) begin
            lock_r <= param_update_pkg::LOCKED;
            was_locked_r <= 1'b0;
          end else if (ctrl_word == `CMD_RESET && was_locked_r) begin
            // a part that was never locked stays open across reset
            lock_r <= param_update_pkg::LOCKED;
            was_locked_r <= 1'b0;
          end
        end
        default: begin
          // an upset state falls back to locked, the safe side
          lock_r <= param_update_pkg::LOCKED;
          was_locked_r <= 1'b0;
        end
      endcase
    end
  end

  // block access enable, class and block selection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      blk_en_r <= 1'b0;
      class_r <= 8'h00;
      block_r <= 8'h00;
    end else if (ctrl_go && (ctrl_word == `CMD_RESET || ctrl_word == `CMD_LOCK)) begin
      blk_en_r <= 1'b0;
    end else if (open_wr) begin
      if (hit_access) begin
        blk_en_r <= (cmd.wdata == `ACCESS_EN_VAL);
      end else if (hit_class && blk_en_r) begin
        class_r <= cmd.wdata;
      end else if (hit_block && blk_en_r) begin
        block_r <= cmd.wdata;
      end
    end
  end

  // staging window, reloaded whenever the selection changes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `BLOCK_BYTES; i++) begin
        win_r[i] <= 8'h00;
      end
      win_r[`OPCFG_B_OFS] <= `OPCFG_B_RST;
    end else if (blk_wr) begin
      if (hit_class || hit_block) begin
        // reload drops unsaved edits; the host must commit first
        for (int i = 0; i < `BLOCK_BYTES; i++) begin
          win_r[i] <= nv_r[sel_idx][i];
        end
      end else if (hit_win) begin
        win_r[win_ofs] <= cmd.wdata;
      end
    end
  end

  // storage; commit happens only on a matching checksum write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int b = 0; b < `NV_BLOCKS; b++) begin
        for (int i = 0; i < `BLOCK_BYTES; i++) begin
          nv_r[b][i] <= 8'h00;
        end
      end
      nv_r[4'(`OPCFG_B_CLASS)][`OPCFG_B_OFS] <= `OPCFG_B_RST;
    end else if (commit_go) begin
      for (int i = 0; i < `BLOCK_BYTES; i++) begin
        nv_r[cur_idx][i] <= win_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      commit_r <= 1'b0;
    end else begin
      // a mismatched checksum is simply dropped
      commit_r <= commit_go;
    end
  end

  // live configuration only follows storage on the reset command
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opcfg_r <= `OPCFG_B_RST;
    end else if (ctrl_go && ctrl_word == `CMD_RESET && lock_r == param_update_pkg::OPEN) begin
      opcfg_r <= nv_r[opcfg_idx][`OPCFG_B_OFS];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      host_temp_r <= 16'h0000;
    end else if (cmd.wr && hit_temp_lo) begin
      host_temp_r[7:0] <= cmd.wdata;
    end else if (cmd.wr && hit_temp_hi) begin
      host_temp_r[15:8] <= cmd.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      temp_r <= 16'h0000;
    end else if (opcfg_r[`OPCFG_B_HOST_TEMP_BIT]) begin
      temp_r <= host_temp_r;
    end else if (int_temp_sel) begin
      temp_r <= int_temp;
    end else begin
      temp_r <= ext_temp;
    end
  end

  // read path; window and checksum read as zero unless access is open
  // data only moves on a read, so it stands until the next one
  always_comb begin
    rdata_nxt = rdata_r;
    if (cmd.rd) begin
      if (hit_sum && blk_en_r) begin
        rdata_nxt = win_chk;
      end else if (hit_win && blk_en_r) begin
        rdata_nxt = win_r[win_ofs];
      end else if (hit_class) begin
        rdata_nxt = class_r;
      end else if (hit_block) begin
        rdata_nxt = block_r;
      end else if (hit_temp_lo) begin
        rdata_nxt = temp_r[7:0];
      end else if (hit_temp_hi) begin
        rdata_nxt = temp_r[15:8];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cmd_rdata = rdata_r;
  assign locked = (lock_r == param_update_pkg::LOCKED);
  assign block_access_on = blk_en_r;
  assign nv_commit = commit_r;
  assign operation_config_b = opcfg_r;
  assign host_temp_write_enable = opcfg_r[`OPCFG_B_HOST_TEMP_BIT];
  assign gauge_temp = temp_r;
endmodule

// ==== dv/param_update_properties.sv ====
// port checks for the parameter block update path
`timescale 1ns/1ps
module param_update_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire param_update_pkg::cmd_req_t cmd,
  input wire logic [7:0] cmd_rdata,
  input wire logic locked,
  input wire logic block_access_on,
  input wire logic nv_commit,
  input wire logic [7:0] operation_config_b,
  input wire logic host_temp_write_enable,
  input wire logic [15:0] ext_temp,
  input wire logic [15:0] int_temp,
  input wire logic int_temp_sel,
  input wire logic [15:0] gauge_temp
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // control word goes low byte first
  sequence s_ctl(logic [15:0] w);
    cmd.wr && cmd.addr == 8'h00 && cmd.wdata == w[7:0]
    ##1 cmd.wr && cmd.addr == 8'h01 && cmd.wdata == w[15:8];
  endsequence
  a_unlock_pair: assert property (locked ##0 s_ctl(16'h0414) ##1 s_ctl(16'h3672) |=> !locked)
    else $error("unlock did not open");
  a_lock_cmd: assert property (s_ctl(16'h0020) |=> locked)
    else $error("lock command ignored");
  a_reset_access: assert property (s_ctl(16'h0041) |=> !block_access_on)
    else $error("access survives reset command");
  a_access_enable: assert property (!locked && cmd.wr && cmd.addr == 8'h61
    && cmd.wdata == 8'h00 |=> block_access_on)
    else $error("block access not enabled");
  a_access_locked: assert property (locked |-> !block_access_on)
    else $error("block access while locked");
  a_commit_cause: assert property (nv_commit |->
    $past(cmd.wr && cmd.addr == 8'h60 && block_access_on))
    else $error("commit without checksum write");
  a_config_change: assert property ($changed(operation_config_b) |->
    $past(cmd.wr && cmd.addr == 8'h01))
    else $error("config changed outside reset command");
  a_temp_flag: assert property (host_temp_write_enable == operation_config_b[7])
    else $error("host temp flag wrong");
  a_gauge_ext: assert property (!host_temp_write_enable && !int_temp_sel
    |=> gauge_temp == $past(ext_temp))
    else $error("external temp not used");
  a_gauge_int: assert property (!host_temp_write_enable && int_temp_sel
    |=> gauge_temp == $past(int_temp))
    else $error("internal temp not used");
endmodule

// ==== dv/host_model.sv ====
// host issuing command reads and writes
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk,
  input wire logic [7:0] cmd_rdata,
  output param_update_pkg::cmd_req_t cmd
);
  initial cmd = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 cmd = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask
  // released lines flip, so a stale copy never looks valid
  task automatic idle();
    @(posedge ref_clk);
    #1 cmd = '{wr: 1'b0, rd: 1'b0, addr: ~cmd.addr, wdata: ~cmd.wdata};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 cmd = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~cmd.wdata};
    idle();
    d = cmd_rdata;
  endtask
  task automatic ctl(input logic [15:0] w);
    wr(8'h00, w[7:0]);
    wr(8'h01, w[15:8]);
  endtask
endmodule

// ==== dv/test_param_block_update.sv ====
// self-checking bench for the parameter block update path
`timescale 1ns/1ps
module test_param_block_update;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] ext_temp = 16'h0bb1;
  logic [15:0] int_temp = 16'h0aa2;
  logic int_temp_sel = 1'b0;
  param_update_pkg::cmd_req_t cmd;
  logic [7:0] cmd_rdata, operation_config_b, d, old;
  logic locked, block_access_on, nv_commit, host_temp_write_enable;
  logic [15:0] gauge_temp;
  int n_fail = 0;
  int tests_run = 0;
  int n_commit = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (nv_commit === 1'b1) n_commit++;
  param_block_update u_dut (.ref_clk(ref_clk), .rstn(rstn), .cmd(cmd), .cmd_rdata(cmd_rdata),
    .locked(locked), .block_access_on(block_access_on), .nv_commit(nv_commit),
    .operation_config_b(operation_config_b), .host_temp_write_enable(host_temp_write_enable),
    .ext_temp(ext_temp), .int_temp(int_temp), .int_temp_sel(int_temp_sel),
    .gauge_temp(gauge_temp));
  host_model u_host (.ref_clk(ref_clk), .cmd_rdata(cmd_rdata), .cmd(cmd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk(locked, 16'h1);
    chk(operation_config_b, 16'h4a);
    chk(gauge_temp, 16'h0);
    u_host.idle();
    chk(gauge_temp, ext_temp);
    int_temp_sel = 1'b1;
    u_host.idle();
    u_host.idle();
    chk(gauge_temp, int_temp);
    int_temp = 16'h0cc3;
    u_host.idle();
    chk(gauge_temp, 16'h0cc3);
    int_temp_sel = 1'b0;
    ext_temp = 16'h0dd4;
    u_host.idle();
    chk(gauge_temp, 16'h0dd4);
    u_host.rd(8'h70, d);
    chk(d, 16'h0);
    u_host.wr(8'h61, 8'h00);
    u_host.idle();
    chk(block_access_on, 16'h0);
  endtask
  task automatic t_update();
    u_host.ctl(16'h0414);
    u_host.ctl(16'h3672);
    u_host.idle();
    chk(locked, 16'h0);
    u_host.wr(8'h61, 8'h00);
    u_host.wr(8'h3e, 8'h40);
    u_host.wr(8'h3f, 8'h01);
    u_host.rd(8'h44, d);
    chk(d, 16'h0);
    u_host.wr(8'h3f, 8'h00);
    u_host.rd(8'h44, d);
    chk(d, 16'h4a);
    u_host.rd(8'h60, old);
    chk(old, 16'hb5);
    u_host.wr(8'h44, 8'hca);
    u_host.rd(8'h44, d);
    chk(d, 16'hca);
    u_host.wr(8'h60, 8'h00);
    u_host.idle();
    u_host.idle();
    chk(16'(n_commit), 16'h0);
    // incremental checksum, as a host would form it
    d = 8'hff - old - 8'h4a;
    u_host.wr(8'h60, 8'hff - (d + 8'hca));
    u_host.wr(8'h3f, 8'h01);
    u_host.wr(8'h3f, 8'h00);
    u_host.rd(8'h44, d);
    chk(d, 16'hca);
    chk(16'(n_commit), 16'h1);
  endtask
  task automatic t_apply();
    u_host.ctl(16'h0041);
    u_host.idle();
    chk(operation_config_b, 16'hca);
    chk(locked, 16'h1);
    chk(host_temp_write_enable, 16'h1);
    u_host.wr(8'h06, 8'h34);
    u_host.wr(8'h07, 8'h12);
    u_host.idle();
    u_host.idle();
    chk(gauge_temp, 16'h1234);
    u_host.ctl(16'h0414);
    u_host.ctl(16'h3672);
    u_host.idle();
    chk(locked, 16'h0);
    u_host.ctl(16'h0020);
    u_host.idle();
    chk(locked, 16'h1);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'b1;
    t_reset();
    t_update();
    t_apply();
    final_report();
  end
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
endmodule
bind param_block_update param_update_checker u_chk (.ref_clk(ref_clk), .rstn(rstn), .cmd(cmd),
  .cmd_rdata(cmd_rdata), .locked(locked), .block_access_on(block_access_on),
  .nv_commit(nv_commit), .operation_config_b(operation_config_b),
  .host_temp_write_enable(host_temp_write_enable), .ext_temp(ext_temp),
  .int_temp(int_temp), .int_temp_sel(int_temp_sel), .gauge_temp(gauge_temp));
